// file: core/sps_defines.vh
// Constants for the status pin strap and interrupt block
`ifndef SPS_DEFINES_VH
`define SPS_DEFINES_VH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define SPS_ADDR_CTRL 8'h00
`define SPS_ADDR_STATUS 8'h04
`define SPS_ADDR_MASK 8'h08
`define SPS_ADDR_IRQSTAT 8'h0c
`define SPS_ADDR_PINCFG 8'h10
`define SPS_ADDR_TUNING 8'h14
`define SPS_ADDR_STRAP 8'h18

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SPS_CTRL_LOOP_BIT 0
`define SPS_CTRL_IRQCLR_BIT 1
`define SPS_IRQSTAT_FLAG_BIT 8
`define SPS_IRQSTAT_SEEN_LSB 16
`define SPS_PINCFG_IRQ_BIT 7
`define SPS_PINCFG_STRIDE 8
`define SPS_STRAP_DIRECT_BIT 8
`define SPS_STRAP_MULT_LSB 16
`define SPS_STRAP_DONE_BIT 24

// ----------------------------------------------------------------
// Reset values and multiply factors
// ----------------------------------------------------------------
`define SPS_RST_MASK 6'h00
`define SPS_RST_PINCFG 32'h00000000
`define SPS_RST_TUNING 16'h0000
`define SPS_MULT_XTAL 6'h28
`define SPS_MULT_DIRECT 6'h00

// ----------------------------------------------------------------
// Bus answers
// ----------------------------------------------------------------
`define SPS_RESP_OKAY 2'b00
`define SPS_RESP_SLVERR 2'b10

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SPS_PULSE_NS 10
`define SPS_CLK_NS 25
`define SPS_SYNC_DEPTH 2

// ----------------------------------------------------------------
// Default tuning words, 16 bits of a 1 GHz sample clock
// ----------------------------------------------------------------
`define SPS_TW0 16'h0000
`define SPS_TW1 16'h09f4
`define SPS_TW2 16'h0d45
`define SPS_TW3 16'h0fba
`define SPS_TW4 16'h13e8
`define SPS_TW5 16'h1797
`define SPS_TW6 16'h1f75
`define SPS_TW7 16'h27d0

`endif

// file: core/sps_rom.v
// Eight entry default tuning word table with registered read
`timescale 1ns/1ps
`include "sps_defines.vh"

module sps_rom (
  input wire clk, // System clock
  input wire rstn, // Async reset, active low
  input wire [2:0] addr, // Strap code
  output reg [15:0] data // Tuning word, one cycle after addr
);

  // ----------------------------------------------------------------
  // Table lookup
  // ----------------------------------------------------------------
  // Registered so the word is stable for the load cycle
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      data <= 16'h0000;
    end else begin
      case (addr) // R9
        3'h0: data <= `SPS_TW0;
        3'h1: data <= `SPS_TW1;
        3'h2: data <= `SPS_TW2;
        3'h3: data <= `SPS_TW3;
        3'h4: data <= `SPS_TW4;
        3'h5: data <= `SPS_TW5;
        3'h6: data <= `SPS_TW6;
        default: data <= `SPS_TW7;
      endcase
    end
  end

endmodule // sps_rom

// file: core/sps_edge.v
// Status flag change detectors with one-shot arming
`timescale 1ns/1ps

module sps_edge #(
  parameter W = 6,
  parameter [5:0] ONE_DIR = 6'h20
) (
  input wire clk, // System clock
  input wire rstn, // Async reset, active low
  input wire [W-1:0] flags, // Live status flags, same clock
  input wire rearm, // Re-arm pulse from interrupt clear
  output reg [W-1:0] evt_r, // One-cycle change pulses
  output reg [W-1:0] seen_r // Detectors that have fired
);

  reg [W-1:0] prev_r;
  wire [W-1:0] change;
  wire [W-1:0] rise;
  wire [W-1:0] newEvt;

  // ----------------------------------------------------------------
  // Change detection
  // ----------------------------------------------------------------
  // Both directions, except rising only where ONE_DIR is set
  assign change = flags ^ prev_r;
  assign rise = flags & ~prev_r;
  assign newEvt = (change & ~ONE_DIR[W-1:0]) | (rise & ONE_DIR[W-1:0]);

  // A fired detector stays quiet until re-armed; new change wins
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prev_r <= {W{1'b0}};
      evt_r <= {W{1'b0}};
      seen_r <= {W{1'b0}};
    end else begin
      prev_r <= flags;
      evt_r <= newEvt & (~seen_r | {W{rearm}}); // R13
      seen_r <= (seen_r & ~{W{rearm}}) | newEvt; // R17
    end
  end

endmodule // sps_edge

// file: core/sps_top.v
// Status pin strapping, pin muxing and interrupt logic
`timescale 1ns/1ps
`include "sps_defines.vh"

// What this block does
// (R1) Reset starts an internal strap pulse during which status pins float.
// (R2) End of strap pulse captures the four pin levels into strap register.
// (R3) End of strap pulse turns the four pins back into driven outputs.
// (R4) External reset repeats the float, capture and drive sequence.
// (R5) Strap bits three to one pick one of eight 16-bit table words.
// (R6) Picked word loads the first tuning word register without update strobe.
// (R7) Strap bit four picks direct clock (1) or crystal multiplier path (0).
// (R8) Crystal multiplier path starts with a multiply factor of forty.
// (R9) Table words give the listed frequencies at a 1 GHz sample clock.
// (R10) Loop stays open after strapped start until software closes it.
// (R11) Any pin may be set to drive the internal interrupt flag.
// (R12) Live status flags are readable any time in a read-only register.
// (R13) Flags watched for changes; estimate-done flag only rising.
// (R14) Only unmasked changes set the active-high interrupt latch.
// (R15) Interrupt assertion snapshots status into interrupt status register.
// (R16) Host writes the clear bit after reading interrupt status.
// (R17) Clear bit drops interrupt, clears snapshot, re-arms detectors.
// (R18) Host should pulse external reset at least 75 ns after supplies.
// (R19) Device acts on falling edge of external reset, may be held.
// (R20) Pins float while external reset is high until its release.
// (R21) Each pin drives OR of its selected internal status indications.
// (R22) Captured strap value holds until next power-up or external reset.

module sps_top #(
  parameter NFLAG = 6,
  parameter [5:0] ONE_DIR = 6'h20,
  parameter AW = 8
) (
  input wire core_clk, // System clock, 40 MHz
  input wire rstn, // Power-up reset, async, active low
  input wire extReset, // External reset pin, active high
  input wire [3:0] statusPinIn, // Status pin levels
  output reg [3:0] statusPinOut, // Status pin drive values
  output reg [3:0] statusPinOe, // Status pin drive enables
  input wire [5:0] statusFlags, // Internal status indications
  output reg [15:0] tuningWord, // First tuning word register
  output reg clkDirect, // 1: direct clock, 0: crystal path
  output reg [5:0] pllMult, // System clock multiply factor
  output reg loopClosed, // Loop close control
  output reg irqFlag, // Latched interrupt flag
  input wire [AW-1:0] s_axi_awaddr, // Write address
  input wire s_axi_awvalid, // Write address valid
  output reg s_axi_awready, // Write address ready
  input wire [31:0] s_axi_wdata, // Write data
  input wire [3:0] s_axi_wstrb, // Write byte strobes
  input wire s_axi_wvalid, // Write data valid
  output reg s_axi_wready, // Write data ready
  output reg [1:0] s_axi_bresp, // Write response
  output reg s_axi_bvalid, // Write response valid
  input wire s_axi_bready, // Write response ready
  input wire [AW-1:0] s_axi_araddr, // Read address
  input wire s_axi_arvalid, // Read address valid
  output reg s_axi_arready, // Read address ready
  output reg [31:0] s_axi_rdata, // Read data
  output reg [1:0] s_axi_rresp, // Read response
  output reg s_axi_rvalid, // Read data valid
  input wire s_axi_rready // Read data ready
);

  // ----------------------------------------------------------------
  // Constants
  // ----------------------------------------------------------------
  // Least pulse time rounds up, never below one cycle
  localparam integer PULSE_RAW =
    (`SPS_PULSE_NS + `SPS_CLK_NS - 1) / `SPS_CLK_NS;
  localparam integer PULSE_CYC = (PULSE_RAW < 1) ? 1 : PULSE_RAW;
  // Pins pass two flops, so the pulse is stretched to let them settle
  localparam integer PULSE_LEN = PULSE_CYC + `SPS_SYNC_DEPTH;
  localparam [2:0] PULSE_LAST = PULSE_LEN[2:0] - 3'd1;

  localparam [1:0] ST_FLOAT = 2'd0;
  localparam [1:0] ST_PULSE = 2'd1;
  localparam [1:0] ST_LOAD = 2'd2;
  localparam [1:0] ST_RUN = 2'd3;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Byte lane merge for strobed writes
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] strb;
    integer b;
    begin
      merge = old;
      for (b = 0; b < 4; b = b + 1) begin
        if (strb[b]) begin
          merge[8*b +: 8] = nw[8*b +: 8];
        end
      end
    end
  endfunction

  // Address decode shared by read and write paths
  function mapped;
    input [AW-1:0] a;
    begin
      case (a)
        `SPS_ADDR_CTRL, `SPS_ADDR_STATUS, `SPS_ADDR_MASK,
        `SPS_ADDR_IRQSTAT, `SPS_ADDR_PINCFG, `SPS_ADDR_TUNING,
        `SPS_ADDR_STRAP: mapped = 1'b1;
        default: mapped = 1'b0;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  reg extMeta_r;
  reg extSync_r;
  reg [3:0] pinMeta_r;
  reg [3:0] pinSync_r;
  reg [1:0] state_r;
  reg [2:0] cnt_r;
  reg [3:0] strap_r;
  reg strapDone_r;
  reg [5:0] mask_r;
  reg [31:0] pinCfg_r;
  reg [5:0] irqStat_r;
  reg irqClr_r;
  reg [3:0] pinNxt;
  reg [31:0] rdMux;
  wire [2:0] romAddr;
  wire [15:0] romData;
  wire [5:0] evt;
  wire [5:0] seen;
  wire setNow;
  wire wrGo;
  wire rdGo;
  wire wrOk;
  wire [31:0] tuneMerged;
  wire [31:0] ctrlMerged;

  // ----------------------------------------------------------------
  // Synchronisers
  // ----------------------------------------------------------------
  // Pin and external reset levels come from outside the clock domain
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      extMeta_r <= 1'b0;
      extSync_r <= 1'b0;
      pinMeta_r <= 4'h0;
      pinSync_r <= 4'h0;
    end else begin
      extMeta_r <= extReset;
      extSync_r <= extMeta_r;
      pinMeta_r <= statusPinIn;
      pinSync_r <= pinMeta_r;
    end
  end

  // ----------------------------------------------------------------
  // Strap sequencer
  // ----------------------------------------------------------------
  // Table address follows the live pins during the pulse so the word
  // is ready in the cycle after capture
  assign romAddr = (state_r == ST_PULSE) ? pinSync_r[2:0] : strap_r[2:0];

  sps_rom u_rom (
    .clk(core_clk),
    .rstn(rstn),
    .addr(romAddr), // R5
    .data(romData)
  );

  // Float, count, capture, load, then run until next external reset
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= ST_PULSE; // R1
      cnt_r <= 3'h0;
      strap_r <= 4'h0;
      strapDone_r <= 1'b0;
      clkDirect <= 1'b0;
      pllMult <= `SPS_MULT_XTAL;
    end else begin
      case (state_r)
        ST_FLOAT: begin
          cnt_r <= 3'h0;
          if (!extSync_r) begin
            state_r <= ST_PULSE; // R19
          end
        end
        ST_PULSE: begin
          if (extSync_r) begin
            state_r <= ST_FLOAT;
          end else if (cnt_r == PULSE_LAST) begin
            strap_r <= pinSync_r; // R2 R22
            strapDone_r <= 1'b1;
            state_r <= ST_LOAD;
          end else begin
            cnt_r <= cnt_r + 3'h1;
          end
        end
        ST_LOAD: begin
          clkDirect <= strap_r[3]; // R7
          pllMult <= strap_r[3] ? `SPS_MULT_DIRECT : `SPS_MULT_XTAL; // R8
          state_r <= extSync_r ? ST_FLOAT : ST_RUN;
        end
        ST_RUN: begin
          if (extSync_r) begin
            state_r <= ST_FLOAT; // R4
            strapDone_r <= 1'b0;
          end
        end
        default: begin
          state_r <= ST_FLOAT;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Edge detectors and interrupt latch
  // ----------------------------------------------------------------
  sps_edge #(
    .W(NFLAG),
    .ONE_DIR(ONE_DIR)
  ) u_edge (
    .clk(core_clk),
    .rstn(rstn),
    .flags(statusFlags),
    .rearm(irqClr_r), // R17
    .evt_r(evt),
    .seen_r(seen)
  );

  assign setNow = |(evt & mask_r); // R14

  // A new event in the clearing cycle keeps the flag up
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      irqFlag <= 1'b0;
      irqStat_r <= 6'h00;
    end else if (extSync_r) begin
      irqFlag <= 1'b0;
      irqStat_r <= 6'h00;
    end else begin
      if (setNow) begin
        irqFlag <= 1'b1; // R14
      end else if (irqClr_r) begin
        irqFlag <= 1'b0; // R17
      end
      if (setNow && (!irqFlag || irqClr_r)) begin
        irqStat_r <= statusFlags; // R15
      end else if (irqClr_r && !setNow) begin
        irqStat_r <= 6'h00; // R17
      end
    end
  end

  // ----------------------------------------------------------------
  // Status pin drivers
  // ----------------------------------------------------------------
  // Per-pin OR of selected flags, or the interrupt flag
  always @* begin : pinMux
    integer p;
    p = 0;
    pinNxt = 4'h0;
    for (p = 0; p < 4; p = p + 1) begin
      if (pinCfg_r[p*`SPS_PINCFG_STRIDE + `SPS_PINCFG_IRQ_BIT]) begin
        pinNxt[p] = irqFlag; // R11
      end else begin
        pinNxt[p] = |(statusFlags &
          pinCfg_r[p*`SPS_PINCFG_STRIDE +: 6]); // R21
      end
    end
  end

  // Pins float except in run; release lags the pin by the sync depth plus one register cycle
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      statusPinOe <= 4'h0; // R1
      statusPinOut <= 4'h0;
    end else if (state_r == ST_RUN && !extSync_r) begin
      statusPinOe <= 4'hf; // R3
      statusPinOut <= pinNxt;
    end else begin
      statusPinOe <= 4'h0; // R20
      statusPinOut <= 4'h0;
    end
  end

  // ----------------------------------------------------------------
  // Bus handshakes
  // ----------------------------------------------------------------
  // Address and data are taken together once both are offered
  assign wrGo = s_axi_awvalid & s_axi_wvalid & ~s_axi_awready &
                ~s_axi_bvalid;
  assign rdGo = s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
  assign wrOk = wrGo & mapped(s_axi_awaddr);
  assign tuneMerged = merge({16'h0000, tuningWord}, s_axi_wdata,
                            s_axi_wstrb);
  assign ctrlMerged = merge({31'h0, loopClosed}, s_axi_wdata,
                            s_axi_wstrb);

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SPS_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `SPS_RESP_OKAY;
      s_axi_rdata <= 32'h00000000;
    end else begin
      s_axi_awready <= wrGo;
      s_axi_wready <= wrGo;
      if (wrGo) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(s_axi_awaddr) ? `SPS_RESP_OKAY :
                       `SPS_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      s_axi_arready <= rdGo;
      if (rdGo) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdMux;
        s_axi_rresp <= mapped(s_axi_araddr) ? `SPS_RESP_OKAY :
                       `SPS_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  // External reset returns mask, pin config and loop control to defaults as well; the tuning word holds until the strap load
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      mask_r <= `SPS_RST_MASK;
      pinCfg_r <= `SPS_RST_PINCFG;
      tuningWord <= `SPS_RST_TUNING;
      loopClosed <= 1'b0;
      irqClr_r <= 1'b0;
    end else if (extSync_r) begin
      mask_r <= `SPS_RST_MASK;
      pinCfg_r <= `SPS_RST_PINCFG;
      loopClosed <= 1'b0; // R10
      irqClr_r <= 1'b0;
    end else begin
      irqClr_r <= 1'b0;
      if (state_r == ST_LOAD) begin
        tuningWord <= romData; // R6
      end else if (wrOk && s_axi_awaddr == `SPS_ADDR_TUNING) begin
        tuningWord <= tuneMerged[15:0];
      end
      if (wrOk && s_axi_awaddr == `SPS_ADDR_CTRL) begin
        loopClosed <= ctrlMerged[`SPS_CTRL_LOOP_BIT]; // R10
        irqClr_r <= s_axi_wstrb[0] &
                    s_axi_wdata[`SPS_CTRL_IRQCLR_BIT]; // R16
      end
      if (wrOk && s_axi_awaddr == `SPS_ADDR_MASK) begin
        mask_r <= s_axi_wstrb[0] ? s_axi_wdata[5:0] : mask_r;
      end
      if (wrOk && s_axi_awaddr == `SPS_ADDR_PINCFG) begin
        pinCfg_r <= merge(pinCfg_r, s_axi_wdata, s_axi_wstrb);
      end
    end
  end

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  // Clear bit is an action and always reads back as zero
  always @* begin
    rdMux = 32'h00000000;
    case (s_axi_araddr)
      `SPS_ADDR_CTRL: rdMux[`SPS_CTRL_LOOP_BIT] = loopClosed;
      `SPS_ADDR_STATUS: rdMux[5:0] = statusFlags; // R12
      `SPS_ADDR_MASK: rdMux[5:0] = mask_r;
      `SPS_ADDR_IRQSTAT: begin
        rdMux[5:0] = irqStat_r; // R15
        rdMux[`SPS_IRQSTAT_FLAG_BIT] = irqFlag;
        rdMux[`SPS_IRQSTAT_SEEN_LSB +: 6] = seen;
      end
      `SPS_ADDR_PINCFG: rdMux = pinCfg_r;
      `SPS_ADDR_TUNING: rdMux[15:0] = tuningWord;
      `SPS_ADDR_STRAP: begin
        rdMux[3:0] = strap_r; // R22
        rdMux[`SPS_STRAP_DIRECT_BIT] = clkDirect;
        rdMux[`SPS_STRAP_MULT_LSB +: 6] = pllMult;
        rdMux[`SPS_STRAP_DONE_BIT] = strapDone_r;
      end
      default: rdMux = 32'h00000000;
    endcase
  end

endmodule // sps_top

// file: verification/sps_board_model.sv
// Board side model: strap resistors and external reset driver
`timescale 1ns/1ps

module sps_board_model #(
  parameter RST_CYC = 4 // Pulse length in clocks
) (
  input wire core_clk, // System clock
  input wire [3:0] strapLevel, // Resistor level per pin
  input wire [3:0] pinOut, // Device drive values
  input wire [3:0] pinOe, // Device drive enables
  input wire pulseReq, // Ask for one reset pulse
  input wire holdReq, // Hold reset high while set
  output wire [3:0] pinLevel, // Resolved pin levels
  output wire extReset // External reset pin
);
  // ----------------------------------------
  // Pins and reset pulse
  // ----------------------------------------
  reg [2:0] cnt = 3'd0;

  // Undriven pins settle to their resistor, never to a stale drive value
  assign pinLevel = (pinOe & pinOut) | (~pinOe & strapLevel);

  // Four clocks high is 100 ns, safely above the 75 ns minimum
  always @(posedge core_clk) begin
    if (cnt != 3'd0)
      cnt <= cnt - 3'd1;
    else if (pulseReq)
      cnt <= RST_CYC[2:0];
  end
  assign extReset = holdReq || (cnt != 3'd0);
endmodule // sps_board_model

// file: verification/sps_top_assertions.sv
// Port level assertions for the strap and interrupt block
`timescale 1ns/1ps

module sps_top_assertions (
  input wire core_clk, // System clock
  input wire rstn, // Reset, active low
  input wire extReset, // External reset pin
  input wire [3:0] statusPinOe, // Pin drive enables
  input wire [5:0] statusFlags, // Live flags
  input wire clkDirect, // Clock source
  input wire [5:0] pllMult, // Multiply factor
  input wire loopClosed, // Loop close control
  input wire irqFlag, // Latched interrupt
  input wire s_axi_awvalid, // Write address valid
  input wire s_axi_wvalid, // Write data valid
  input wire s_axi_awready, // Write address ready
  input wire s_axi_wready, // Write data ready
  input wire s_axi_bvalid, // Write response valid
  input wire s_axi_arvalid, // Read address valid
  input wire s_axi_arready, // Read address ready
  input wire s_axi_rvalid // Read data valid
);
  // ----------------------------------------
  // Checks on the system clock
  // ----------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  // Pins float for the strap window, then all four drive
  AST_PWRUP_FLOAT: assert property ($rose(rstn) |->
    (statusPinOe == 4'h0) [*3] ##[1:6] (statusPinOe == 4'hf))
    else $error("Strap window after power-up wrong");
  AST_EXT_FLOAT: assert property (extReset [*4] |->
    statusPinOe == 4'h0) else $error("Pins driven in external reset");
  AST_SRC_MULT: assert property (
    pllMult == (clkDirect ? 6'h00 : 6'h28))
    else $error("Multiplier does not match clock source");
  // Source may only move inside a strap window
  AST_STRAP_HOLD: assert property ($changed(clkDirect) |->
    statusPinOe == 4'h0) else $error("Strap changed outside reset");
  // Flags are held between changes, so a five deep look back suffices
  AST_IRQ_CAUSE: assert property ($rose(irqFlag) |->
    $past(statusFlags, 2) != $past(statusFlags, 5))
    else $error("Interrupt without flag change");
  AST_IRQ_CLEAR: assert property ($fell(irqFlag) |->
    $past(s_axi_bvalid) || $past(s_axi_bvalid, 2) ||
    $past(s_axi_bvalid, 3) || extReset || $past(extReset, 2))
    else $error("Interrupt dropped without clear");
  AST_LOOP_SET: assert property ($rose(loopClosed) |->
    s_axi_bvalid || $past(s_axi_bvalid))
    else $error("Loop closed without a write");
  AST_WR_ANSWER: assert property (s_axi_awvalid && s_axi_wvalid &&
    !s_axi_awready && !s_axi_bvalid |=>
    s_axi_awready && s_axi_wready && s_axi_bvalid)
    else $error("Write not answered next cycle");
  AST_RD_ANSWER: assert property (s_axi_arvalid && !s_axi_arready &&
    !s_axi_rvalid |=> s_axi_arready && s_axi_rvalid)
    else $error("Read not answered next cycle");
  AST_RD_ONE: assert property (s_axi_arready |=> !s_axi_arready)
    else $error("Read ready stood too long");

  COV_IRQ: cover property ($rose(irqFlag));
  COV_DRIVE: cover property ($rose(statusPinOe[3]));
  COV_DIRECT: cover property ($rose(clkDirect));
endmodule // sps_top_assertions

bind sps_top sps_top_assertions chk_u (.*);

// file: verification/testbench.sv
// Self-checking bench for the strap and interrupt block
`timescale 1ns/1ps
`include "sps_defines.vh"

module testbench;
  reg core_clk = 1'b0, rstn = 1'b0, pulseReq = 1'b0, holdReq = 1'b0;
  reg awv = 1'b0, wv = 1'b0, arv = 1'b0, bRdy = 1'b0, rRdy = 1'b0;
  reg [7:0] awAddr = 8'h00, arAddr = 8'h00;
  reg [31:0] wData = 32'h0, rd;
  reg [5:0] flags = 6'h00;
  reg [3:0] strap = 4'h5;
  reg [1:0] resp;
  wire [3:0] pinOut, pinOe, pinIn;
  wire [15:0] tw;
  wire [5:0] mult;
  wire [31:0] rData;
  wire [1:0] bResp, rResp;
  wire awRdy, wRdy, bV, arRdy, rV, direct, loopC, irq, extRst;
  integer failCount = 0, checks = 0;

  always #12.5 core_clk = ~core_clk;

  sps_top dut_u (
    .core_clk(core_clk), .rstn(rstn), .extReset(extRst),
    .statusPinIn(pinIn), .statusPinOut(pinOut), .statusPinOe(pinOe),
    .statusFlags(flags), .tuningWord(tw), .clkDirect(direct),
    .pllMult(mult), .loopClosed(loopC), .irqFlag(irq),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awv), .s_axi_awready(awRdy),
    .s_axi_wdata(wData), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
    .s_axi_wready(wRdy), .s_axi_bresp(bResp), .s_axi_bvalid(bV),
    .s_axi_bready(bRdy), .s_axi_araddr(arAddr), .s_axi_arvalid(arv),
    .s_axi_arready(arRdy), .s_axi_rdata(rData), .s_axi_rresp(rResp),
    .s_axi_rvalid(rV), .s_axi_rready(rRdy)
  );

  sps_board_model board_u (
    .core_clk(core_clk), .strapLevel(strap), .pinOut(pinOut),
    .pinOe(pinOe), .pulseReq(pulseReq), .holdReq(holdReq),
    .pinLevel(pinIn), .extReset(extRst)
  );

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task chk(input [31:0] got, input [31:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        failCount = failCount + 1;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask

  // Word from the output frequency at a 1 GHz sample clock
  function [15:0] twOf(input [2:0] c);
    real f;
    begin
      case (c)
        3'd1: f = 38.87939;
        3'd2: f = 51.83411;
        3'd3: f = 61.43188;
        3'd4: f = 77.75879;
        3'd5: f = 92.14783;
        3'd6: f = 122.87903;
        3'd7: f = 155.51758;
        default: f = 0.0;
      endcase
      twOf = 16'($rtoi(f * 65.536 + 0.5));
    end
  endfunction

  // Trailing edge keeps the next call from reassigning in one step
  task wr(input [7:0] a, input [31:0] d);
    begin
      awAddr <= a;
      wData <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      bRdy <= 1'b1;
      @(posedge core_clk);
      while (awRdy !== 1'b1)
        @(posedge core_clk);
      awv <= 1'b0;
      wv <= 1'b0;
      while (bV !== 1'b1)
        @(posedge core_clk);
      resp = bResp;
      bRdy <= 1'b0;
      @(posedge core_clk);
    end
  endtask

  task rdReg(input [7:0] a);
    begin
      arAddr <= a;
      arv <= 1'b1;
      rRdy <= 1'b1;
      @(posedge core_clk);
      while (rV !== 1'b1)
        @(posedge core_clk);
      rd = rData;
      resp = rResp;
      arv <= 1'b0;
      rRdy <= 1'b0;
      @(posedge core_clk);
    end
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task strapAll;
    integer c;
    begin
      for (c = 0; c < 16; c = c + 1) begin
        strap <= c[3:0];
        pulseReq <= 1'b1;
        @(posedge core_clk);
        pulseReq <= 1'b0;
        repeat (20) @(posedge core_clk);
        chk(tw, twOf(c[2:0]));
        chk(direct, c[3]);
        chk(mult, c[3] ? 6'h00 : 6'h28);
        chk(pinOe, 4'hf);
        rdReg(`SPS_ADDR_STRAP);
        chk(rd[3:0], c[3:0]);
      end
    end
  endtask

  // Strap only lands when a held reset finally falls
  task holdReset;
    begin
      strap <= 4'h2;
      repeat (10) @(posedge core_clk);
      chk(tw, twOf(3'd7));
      holdReq <= 1'b1;
      repeat (10) @(posedge core_clk);
      chk(pinOe, 4'h0);
      chk(direct, 1'b1);
      holdReq <= 1'b0;
      repeat (12) @(posedge core_clk);
      chk(tw, twOf(3'd2));
      chk(direct, 1'b0);
    end
  endtask

  task regAccess;
    begin
      chk(loopC, 1'b0);
      flags <= 6'h2a;
      wr(`SPS_ADDR_STATUS, 32'h0);
      chk(resp, `SPS_RESP_OKAY);
      wr(8'h1c, 32'h0);
      chk(resp, `SPS_RESP_SLVERR);
      rdReg(`SPS_ADDR_STATUS);
      chk(rd, 32'h2a);
      rdReg(8'h1c);
      chk(resp, `SPS_RESP_SLVERR);
      wr(`SPS_ADDR_CTRL, 32'h1);
      chk(loopC, 1'b1);
      wr(`SPS_ADDR_CTRL, 32'h0);
    end
  endtask

  task irqFlow;
    begin
      wr(`SPS_ADDR_CTRL, 32'h2);
      wr(`SPS_ADDR_MASK, 32'h21);
      wr(`SPS_ADDR_PINCFG, 32'h680);
      chk(pinOut[1], 1'b1);
      flags <= 6'h28;
      repeat (5) @(posedge core_clk);
      chk({irq, pinOut[1]}, 2'b00);
      flags <= 6'h08;
      repeat (5) @(posedge core_clk);
      chk(irq, 1'b0);
      flags <= 6'h09;
      repeat (5) @(posedge core_clk);
      chk({irq, pinOut[0]}, 2'b11);
      rdReg(`SPS_ADDR_IRQSTAT);
      chk(rd & 32'h1ff, 32'h109);
      wr(`SPS_ADDR_CTRL, 32'h2);
      repeat (2) @(posedge core_clk);
      chk(irq, 1'b0);
      rdReg(`SPS_ADDR_IRQSTAT);
      chk(rd & 32'h1ff, 32'h0);
      flags <= 6'h08;
      repeat (5) @(posedge core_clk);
      chk(irq, 1'b1);
      wr(`SPS_ADDR_CTRL, 32'h2);
      flags <= 6'h28;
      repeat (5) @(posedge core_clk);
      chk(irq, 1'b1);
    end
  endtask

  task closeOut;
    begin
      $display("checks=%0d mismatches=%0d", checks, failCount);
      if (failCount == 0 && checks > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask

  // Whole run is about 500 clocks; eight times that means a hang
  initial begin
    #100000;
    failCount = failCount + 1;
    closeOut;
  end

  initial begin
    repeat (3) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    chk(pinOe, 4'h0);
    repeat (8) @(posedge core_clk);
    chk(pinOe, 4'hf);
    chk(tw, twOf(3'd5));
    strapAll;
    holdReset;
    regAccess;
    irqFlow;
    closeOut;
  end
endmodule // testbench
